// ===== hdl/fpd_fan_pwm.sv
// fan drive duty select with serial register access
// Summary of operation
// - four bit duty setting, read and write
// - duty spans 30 to 100 percent, 4.67% steps
// - linear decode, code 0 30%, 15 100%
// - analog mode, open input uses code 0010
// - config source bit picks bus or analog
// - higher analog level gives higher duty
// - eight bit read only maker value
// - two bit read only variant value
`timescale 1ns/10ps
module fpd_fan_pwm #(
  parameter int PWM_DIV = fpd_pkg::PWM_DIV_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic smb_scl,
  input wire logic smb_sda_in,
  output logic smb_sda_out,
  output logic smb_sda_oe_n,
  input wire logic [7:0] vin_level,
  input wire logic vin_open,
  output logic fan_drive
);
  logic rst_q1;
  logic rst_sync_n;
  logic [7:0] cfg;
  logic [3:0] duty_set;
  logic vin_stat;
  logic vin_caught;
  fpd_pkg::fpd_req_s req;
  logic req_stb;
  logic [7:0] rdata;
  logic [15:0] div_cnt;
  logic tick;
  logic [7:0] phase;
  logic [7:0] duty_live;
  logic [7:0] next_duty;
  logic [15:0] vin_prod;

  // code to on-steps out of a 150 step period
  function automatic logic [7:0] code_steps(input logic [3:0] code);
    logic [11:0] prod;
    prod = {4'h0, fpd_pkg::DUTY_STEP} * {8'h00, code};
    return fpd_pkg::DUTY_BASE + prod[7:0];
  endfunction

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_sync_n <= rst_q1;
    end
  end

  fpd_smb_slave #(
    .ADDR(fpd_pkg::SMB_ADDR)
  ) u_smb (
    .clk(ref_clk),
    .rst_n(rst_sync_n),
    .scl(smb_scl),
    .sda_in(smb_sda_in),
    .sda_out(smb_sda_out),
    .sda_oe_n(smb_sda_oe_n),
    .req(req),
    .req_stb(req_stb),
    .rdata(rdata)
  );

  // register writes; the duty setting stores in either mode
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg <= fpd_pkg::CONFIG_RESET;
      duty_set <= fpd_pkg::DUTY_RESET;
    end else if (req_stb && req.wr) begin
      if (req.cmd == fpd_pkg::CMD_CONFIG) begin
        cfg <= req.data;
      end
      if (req.cmd == fpd_pkg::CMD_DUTY) begin
        duty_set <= req.data[3:0];
      end
    end
  end

  // open input is judged once, just after reset release
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      vin_stat <= 1'b0;
      vin_caught <= 1'b0;
    end else if (!vin_caught) begin
      vin_stat <= vin_open;
      vin_caught <= 1'b1;
    end
  end

  // maker and variant ignore writes and return constants
  always_comb begin
    unique case (req.cmd)
      fpd_pkg::CMD_CONFIG: rdata = cfg;
      fpd_pkg::CMD_STATUS: rdata = 8'(vin_stat) << fpd_pkg::STAT_VOPEN_BIT;
      fpd_pkg::CMD_DUTY: rdata = {4'h0, duty_set};
      fpd_pkg::CMD_MAKER: rdata = fpd_pkg::MAKER_VALUE;
      fpd_pkg::CMD_VARIANT:
        rdata = {6'h00, fpd_pkg::VARIANT_VALUE};
      default: rdata = 8'h00;
    endcase
  end

  // analog level 0..255 scales onto 45..150 steps
  assign vin_prod = {8'h00, vin_level} * {8'h00, fpd_pkg::DUTY_SPAN};

  always_comb begin
    if (cfg[fpd_pkg::CFG_SRC_BIT]) begin
      next_duty = code_steps(duty_set);
    end else if (vin_stat) begin
      next_duty = code_steps(fpd_pkg::DUTY_OPEN_CODE);
    end else begin
      next_duty = fpd_pkg::DUTY_BASE +
        8'(vin_prod / {8'h00, fpd_pkg::VIN_FULL});
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      div_cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (div_cnt == 16'(PWM_DIV - 1)) begin
      div_cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // duty only changes at a period start, so no runt pulses
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase <= 8'h00;
      duty_live <= 8'h00;
      fan_drive <= 1'b0;
    end else if (tick) begin
      if (phase == fpd_pkg::PWM_STEPS - 8'h01) begin
        phase <= 8'h00;
        duty_live <= next_duty;
        fan_drive <= next_duty != 8'h00;
      end else begin
        phase <= phase + 8'h01;
        fan_drive <= (phase + 8'h01) < duty_live;
      end
    end
  end
endmodule

// ===== hdl/fpd_pkg.sv
// constants and carrier types for the fan duty select block
package fpd_pkg;
  // register command codes on the serial bus
  localparam logic [7:0] CMD_CONFIG = 8'h04;
  localparam logic [7:0] CMD_STATUS = 8'h05;
  localparam logic [7:0] CMD_DUTY = 8'h08;
  localparam logic [7:0] CMD_MAKER = 8'hFE;
  localparam logic [7:0] CMD_VARIANT = 8'hFF;
  // reset values and the open input code
  localparam logic [7:0] CONFIG_RESET = 8'h0A;
  localparam logic [3:0] DUTY_RESET = 4'h2;
  localparam logic [3:0] DUTY_OPEN_CODE = 4'h2;
  // field positions
  localparam int CFG_SRC_BIT = 5;
  localparam int STAT_VOPEN_BIT = 2;
  // identity values, arbitrary
  localparam logic [7:0] MAKER_VALUE = 8'hA5;
  localparam logic [1:0] VARIANT_VALUE = 2'h2;
  // pwm period in steps: 30% = 45, one code step = 7 steps
  localparam logic [7:0] PWM_STEPS = 8'h96;
  localparam logic [7:0] DUTY_BASE = 8'h2D;
  localparam logic [7:0] DUTY_STEP = 8'h07;
  localparam logic [7:0] DUTY_SPAN = 8'h69;
  localparam logic [7:0] VIN_FULL = 8'hFF;
  // pwm rate: target period in microseconds, clock period in ns
  localparam int PWM_PERIOD_US = 33000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int PWM_DIV_CYCLES =
    (PWM_PERIOD_US * 1000) / (CLK_PERIOD_NS * 150);
  // default serial address
  localparam logic [6:0] SMB_ADDR = 7'h1B;

  typedef struct packed {
    logic wr;
    logic [7:0] cmd;
    logic [7:0] data;
  } fpd_req_s;

  typedef enum logic [3:0] {
    SM_IDLE, SM_ADDR, SM_ADDR_ACK, SM_CMD, SM_CMD_ACK,
    SM_WDATA, SM_WDATA_ACK, SM_RDATA, SM_RDATA_ACK
  } fpd_smb_e;
endpackage

// ===== hdl/fpd_smb_slave.sv
// serial bus slave: byte write and byte read of command registers
`timescale 1ns/10ps
module fpd_smb_slave #(
  parameter logic [6:0] ADDR = fpd_pkg::SMB_ADDR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output fpd_pkg::fpd_req_s req,
  output logic req_stb,
  input wire logic [7:0] rdata
);
  fpd_pkg::fpd_smb_e state;
  logic scl_q;
  logic sda_q;
  logic [7:0] shift;
  logic [7:0] tx;
  logic [3:0] cnt;
  logic rw;
  logic nack;
  logic start_c;
  logic stop_c;
  logic rise;
  logic fall;

  assign start_c = scl & scl_q & sda_q & ~sda_in;
  assign stop_c = scl & scl_q & ~sda_q & sda_in;
  assign rise = scl & ~scl_q;
  assign fall = ~scl & scl_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= fpd_pkg::SM_IDLE;
      shift <= 8'h00;
      tx <= 8'h00;
      cnt <= 4'h0;
      rw <= 1'b0;
      nack <= 1'b1;
      sda_oe_n <= 1'b1;
      req <= '0;
      req_stb <= 1'b0;
    end else begin
      req_stb <= 1'b0;
      if (stop_c) begin
        state <= fpd_pkg::SM_IDLE;
        sda_oe_n <= 1'b1;
      end else if (start_c) begin
        state <= fpd_pkg::SM_ADDR;
        cnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (rise) begin
        unique case (state)
          fpd_pkg::SM_ADDR, fpd_pkg::SM_CMD, fpd_pkg::SM_WDATA: begin
            shift <= {shift[6:0], sda_in};
            cnt <= cnt + 4'h1;
          end
          fpd_pkg::SM_RDATA: begin
            cnt <= cnt + 4'h1;
          end
          fpd_pkg::SM_RDATA_ACK: begin
            nack <= sda_in;
          end
          default: begin
          end
        endcase
      end else if (fall) begin
        unique case (state)
          fpd_pkg::SM_ADDR: begin
            if (cnt == 4'h8) begin
              if (shift[7:1] == ADDR) begin
                rw <= shift[0];
                sda_oe_n <= 1'b0;
                state <= fpd_pkg::SM_ADDR_ACK;
              end else begin
                state <= fpd_pkg::SM_IDLE;
              end
            end
          end
          fpd_pkg::SM_ADDR_ACK: begin
            cnt <= 4'h0;
            if (rw) begin
              // read answers from the last command byte
              tx <= {rdata[6:0], 1'b0};
              sda_oe_n <= rdata[7];
              state <= fpd_pkg::SM_RDATA;
            end else begin
              sda_oe_n <= 1'b1;
              state <= fpd_pkg::SM_CMD;
            end
          end
          fpd_pkg::SM_CMD: begin
            if (cnt == 4'h8) begin
              req.cmd <= shift;
              sda_oe_n <= 1'b0;
              state <= fpd_pkg::SM_CMD_ACK;
            end
          end
          fpd_pkg::SM_CMD_ACK, fpd_pkg::SM_WDATA_ACK: begin
            cnt <= 4'h0;
            sda_oe_n <= 1'b1;
            state <= fpd_pkg::SM_WDATA;
          end
          fpd_pkg::SM_WDATA: begin
            if (cnt == 4'h8) begin
              req.wr <= 1'b1;
              req.data <= shift;
              req_stb <= 1'b1;
              sda_oe_n <= 1'b0;
              state <= fpd_pkg::SM_WDATA_ACK;
            end
          end
          fpd_pkg::SM_RDATA: begin
            if (cnt == 4'h8) begin
              sda_oe_n <= 1'b1;
              state <= fpd_pkg::SM_RDATA_ACK;
            end else begin
              sda_oe_n <= tx[7];
              tx <= {tx[6:0], 1'b0};
            end
          end
          fpd_pkg::SM_RDATA_ACK: begin
            cnt <= 4'h0;
            if (!nack) begin
              tx <= {rdata[6:0], 1'b0};
              sda_oe_n <= rdata[7];
              state <= fpd_pkg::SM_RDATA;
            end else begin
              state <= fpd_pkg::SM_IDLE;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule

// ===== sim/fpd_fan_pwm_sva.sv
// port-level checks for the fan duty select block
`timescale 1ns/10ps
module fpd_fan_pwm_sva #(
  parameter int PWM_DIV = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic smb_scl,
  input wire logic smb_sda_out,
  input wire logic smb_sda_oe_n,
  input wire logic [7:0] vin_level,
  input wire logic vin_open,
  input wire logic fan_drive
);
  localparam int PER = 150 * PWM_DIV;
  int hi;
  int lo;
  int gap;
  logic seen;
  logic quiet;
  logic [7:0] vcap;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // any bus clock low ends the untouched analog-mode window
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi <= 0;
      lo <= 0;
      gap <= 0;
      seen <= 1'b0;
      quiet <= 1'b1;
      vcap <= 8'h00;
    end else begin
      hi <= fan_drive ? hi + 1 : 0;
      lo <= fan_drive ? 0 : lo + 1;
      gap <= $rose(fan_drive) ? 1 : gap + 1;
      seen <= seen | $rose(fan_drive);
      quiet <= quiet & smb_scl;
      if ($rose(fan_drive)) vcap <= vin_level;
    end
  end
  chk_on_floor: assert property (
    $fell(fan_drive) |-> hi >= 45 * PWM_DIV) else $error("on time short");
  chk_on_grain: assert property (
    $fell(fan_drive) |-> hi % PWM_DIV == 0) else $error("on time off grid");
  // full duty skips rises, so only a whole number of periods is required
  chk_rise_period: assert property (
    $rose(fan_drive) && seen |-> gap % PER == 0) else $error("bad period");
  chk_off_ceiling: assert property (
    $rose(fan_drive) && seen |-> lo <= 105 * PWM_DIV) else $error("off long");
  chk_open_duty: assert property (
    $fell(fan_drive) && quiet && vin_open |-> hi == 59 * PWM_DIV)
    else $error("open input duty wrong");
  chk_analog_map: assert property (
    $fell(fan_drive) && quiet && !vin_open
    |-> hi == (45 + int'(vcap) * 105 / 255) * PWM_DIV)
    else $error("analog duty wrong");
  chk_ack_steady: assert property (
    smb_scl && $past(smb_scl) |-> $stable(smb_sda_oe_n))
    else $error("data moved while bus clock high");
  chk_sda_low: assert property (
    smb_sda_out == 1'b0) else $error("open drain value not low");
  cover property ($fell(smb_sda_oe_n));
  cover property ($fell(fan_drive) && quiet && vin_open);
  cover property ($rose(fan_drive) && seen);
endmodule
bind fpd_fan_pwm fpd_fan_pwm_sva #(.PWM_DIV(PWM_DIV)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .smb_scl(smb_scl),
  .smb_sda_out(smb_sda_out), .smb_sda_oe_n(smb_sda_oe_n),
  .vin_level(vin_level), .vin_open(vin_open), .fan_drive(fan_drive));

// ===== sim/fpd_fan_pwm_tb_top.sv
// self-checking bench for the fan duty select block
`timescale 1ns/10ps
module fpd_fan_pwm_tb_top;
  localparam int DIV = 2;
  localparam int PER = 150 * DIV;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl;
  logic sda_drv;
  logic sda_out;
  logic sda_oe_n;
  logic fan_drive;
  logic [7:0] vin_level = 8'h00;
  logic vin_open = 1'b0;
  logic [7:0] rv;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  // mode (0 analog level, 1 bus code), value, expected on steps
  int rows [7][3] = '{'{0, 0, 45}, '{0, 128, 97}, '{0, 255, 150},
    '{1, 0, 45}, '{1, 1, 52}, '{1, 7, 94}, '{1, 15, 150}};
  wire sda = sda_drv & (sda_oe_n | sda_out);
  always #25 ref_clk = ~ref_clk;
  fpd_fan_pwm #(.PWM_DIV(DIV)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .smb_scl(scl), .smb_sda_in(sda), .smb_sda_out(sda_out),
    .smb_sda_oe_n(sda_oe_n), .vin_level(vin_level), .vin_open(vin_open),
    .fan_drive(fan_drive));
  fpd_smb_host host (.clk(ref_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  // ceiling well above the roughly 20k cycles the sequence needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end
  task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // new duty lands at a period start; any full period then shows it
  // skip past the next wrap so the window holds the new duty only
  task automatic meas();
    n = 0;
    repeat (PER + 20) @(posedge ref_clk);
    repeat (3 * PER) begin
      @(posedge ref_clk);
      if (fan_drive === 1'b1) n++;
    end
    n = n / 3;
  endtask
  // analog level changes only in the off phase, away from the wrap
  task automatic wait_fall();
    int k;
    for (k = 0; k < 2 * PER && fan_drive !== 1'b1; k++) @(posedge ref_clk);
    for (k = 0; k < 2 * PER && fan_drive !== 1'b0; k++) @(posedge ref_clk);
  endtask
  task automatic do_reset(input logic op);
    rst_n <= 1'b0;
    vin_open <= op;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    do_reset(1'b0);
    foreach (rows[i]) begin
      if (rows[i][0] == 0) begin
        wait_fall();
        vin_level <= 8'(rows[i][1]);
      end else begin
        host.wr(fpd_pkg::CMD_CONFIG, 8'h2A);
        host.wr(fpd_pkg::CMD_DUTY, 8'(rows[i][1]));
        host.rd(fpd_pkg::CMD_DUTY, rv);
        ck({8'h00, rv}, 16'(rows[i][1]));
      end
      meas();
      ck(16'(n), 16'(rows[i][2] * DIV));
      $display("row %0d done", i);
    end
    host.wr(fpd_pkg::CMD_MAKER, 8'h00);
    host.rd(fpd_pkg::CMD_MAKER, rv);
    ck({8'h00, rv}, {8'h00, fpd_pkg::MAKER_VALUE});
    host.rd(fpd_pkg::CMD_VARIANT, rv);
    ck({8'h00, rv}, {14'h0, fpd_pkg::VARIANT_VALUE});
    host.rd(8'h10, rv);
    ck({8'h00, rv}, 16'h0000);
    host.rd(fpd_pkg::CMD_STATUS, rv);
    ck({8'h00, rv}, 16'h0000);
    $display("identity reads done");
    // back to analog with level at top: stored code must not steer
    host.wr(fpd_pkg::CMD_CONFIG, fpd_pkg::CONFIG_RESET);
    host.wr(fpd_pkg::CMD_DUTY, 8'h05);
    host.rd(fpd_pkg::CMD_DUTY, rv);
    ck({8'h00, rv}, 16'h0005);
    meas();
    ck(16'(n), 16'(PER));
    $display("analog write test done");
    do_reset(1'b1);
    meas();
    ck(16'(n), 16'(59 * DIV));
    host.rd(fpd_pkg::CMD_STATUS, rv);
    ck({8'h00, rv}, 16'(1 << fpd_pkg::STAT_VOPEN_BIT));
    host.rd(fpd_pkg::CMD_DUTY, rv);
    ck({8'h00, rv}, {12'h000, fpd_pkg::DUTY_RESET});
    ck(16'(host.nacks), 16'h0000);
    $display("open input test done");
    give_verdict();
  end
endmodule

// ===== sim/fpd_smb_host.sv
// serial bus host model for the fan block registers
`timescale 1ns/10ps
module fpd_smb_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl = 1'b1,
  output logic sda_drv = 1'b1
);
  int nacks = 0;
  // data moves a clock after the bus clock, never with it
  task automatic set(input logic s, input logic d);
    scl <= s;
    @(posedge clk);
    sda_drv <= d;
    repeat (4) @(posedge clk);
  endtask
  task automatic start();
    set(1'b0, 1'b1);
    set(1'b1, 1'b1);
    set(1'b1, 1'b0);
  endtask
  task automatic stop();
    set(1'b0, 1'b0);
    set(1'b1, 1'b0);
    set(1'b1, 1'b1);
  endtask
  // eight data bits then the ack slot, msb first
  task automatic xfer(input logic [8:0] b, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      set(1'b0, b[i]);
      set(1'b1, b[i]);
      r[i] = sda;
    end
    if (b != 9'h1FF && r[0] !== 1'b0) nacks++;
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic [8:0] r;
    start();
    xfer({fpd_pkg::SMB_ADDR, 2'b01}, r);
    xfer({c, 1'b1}, r);
    xfer({d, 1'b1}, r);
    stop();
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    logic [8:0] r;
    start();
    xfer({fpd_pkg::SMB_ADDR, 2'b01}, r);
    xfer({c, 1'b1}, r);
    start();
    xfer({fpd_pkg::SMB_ADDR, 2'b11}, r);
    xfer(9'h1FF, r);
    d = r[8:1];
    stop();
  endtask
endmodule
